// [core/fsc_fifo.sv]
// Small input buffer of the stream controller
`timescale 1ns/1ps
`default_nettype none
module fsc_fifo #(
    parameter int unsigned W     = 18,
    parameter int unsigned DEPTH = 6,
    parameter int unsigned LW    = $clog2(DEPTH + 1)
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [LW-1:0]      level
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [LW-1:0] cnt_reg;
    wire           push = in_valid & in_ready;
    wire           pop  = out_valid & out_ready;
    wire [AW-1:0]  wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    wire [AW-1:0]  rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;

    // Full and empty come straight from the occupancy count
    assign in_ready  = (cnt_reg != LW'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign level     = cnt_reg;

    // Storage is never reset; a reset pulse still empties the buffer by clearing pointers and count
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    // Pointers and count are control state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_next;
            if (pop)  rd_reg <= rd_next;
            cnt_reg <= cnt_reg + LW'(push) - LW'(pop);
        end
    end
endmodule : fsc_fifo
`default_nettype wire

// [core/fsc_stream_ctrl.sv]
// Stream control of the filter core with its register slave
`timescale 1ns/1ps
`default_nettype none
module fsc_stream_ctrl
    import fsc_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = 6,
    parameter int unsigned LW        = $clog2(BUF_DEPTH + 1)
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Register bus
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Sample input
    input  wire logic        sink_valid,
    output logic             sink_ready,
    input  wire fsc_sink_s   sink_beat,
    // Result output
    output logic             source_valid,
    input  wire logic        source_ready,
    output fsc_source_s      source_beat
);
    localparam logic [FSC_CH_W-1:0] LAST_CH = FSC_CH_W'(FSC_NUM_CH - 1);

    // Control registers
    fsc_arch_e   arch_reg;
    logic [7:0]  ccount_reg;
    logic [3:0]  units_reg;
    logic [31:0] rcount_reg;

    // Stream state
    logic                  ready_en_reg;
    logic                  fill_reg;
    logic                  stage_valid_reg;
    logic [7:0]            stage_cnt_reg;
    logic [FSC_DATA_W-1:0] stage_data_reg;
    logic [FSC_CH_W-1:0]   stage_chan_reg;
    logic [FSC_CH_W-1:0]   in_chan_reg;
    logic                  out_valid_reg;
    fsc_source_s           out_beat_reg;
    logic [FSC_DATA_W-1:0] hist_mem [FSC_NUM_CH];

    // Buffer wires
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic [$bits(fsc_sink_s)-1:0] buf_q;
    logic [LW-1:0]         buf_level;
    fsc_sink_s             buf_beat;
    assign buf_beat = fsc_sink_s'(buf_q);

    // Input period in cycles for the selected architecture
    logic [7:0] period;
    wire  [7:0] units8  = (units_reg == '0) ? 8'h01 : {4'h0, units_reg};
    wire  [7:0] width8  = 8'(FSC_DATA_W);
    wire  [7:0] mbs_per = width8 / units8;
    always_comb begin
        unique case (arch_reg)
            FSC_ARCH_PARALLEL:
                period = 8'h01;
            FSC_ARCH_MULTICYCLE_VARIABLE_ARCHITECTURE:
                period = (ccount_reg == '0) ? 8'h01 : ccount_reg;
            FSC_ARCH_MULTIBIT_SERIAL:
                period = (mbs_per == '0) ? 8'h01 : mbs_per;
            FSC_ARCH_SERIAL:
                period = width8 + 8'h01;
        endcase
    end

    // Handshake terms; compute stage and buffer reads freeze while the enable is low
    wire out_free = !out_valid_reg || source_ready;
    wire advance  = clk_en && stage_valid_reg && (stage_cnt_reg == 8'h01)
                    && out_free;
    wire load     = clk_en && buf_out_valid
                    && (!stage_valid_reg || advance);
    wire take     = sink_valid && sink_ready;

    // Accept stays off in reset; refill waits for empty, giving bursts
    assign sink_ready   = rst_n && ready_en_reg && fill_reg
                          && buf_in_ready;
    assign source_valid = rst_n && out_valid_reg;
    assign source_beat  = out_beat_reg;

    // Channel of the sample being loaded; group-first restarts at zero
    wire [FSC_CH_W-1:0] load_chan = buf_beat.sop ? '0 : in_chan_reg;
    wire [FSC_CH_W-1:0] next_chan =
        (load_chan == LAST_CH) ? '0 : load_chan + 1'b1;
    wire [FSC_OUT_W-1:0] result =
        {stage_data_reg[FSC_DATA_W-1], stage_data_reg}
        + {hist_mem[stage_chan_reg][FSC_DATA_W-1],
           hist_mem[stage_chan_reg]};

    fsc_fifo #(
        .W     ($bits(fsc_sink_s)),
        .DEPTH (BUF_DEPTH),
        .LW    (LW)
    ) u_buf (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (take),
        .in_ready  (buf_in_ready),
        .in_data   (sink_beat),
        .out_valid (buf_out_valid),
        .out_ready (load),
        .out_data  (buf_q),
        .level     (buf_level)
    );

    // Accept enable and refill hysteresis run regardless of the enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ready_en_reg <= 1'b0;
            fill_reg     <= 1'b1;
        end else begin
            ready_en_reg <= 1'b1;
            if (!buf_in_ready)
                fill_reg <= 1'b0;
            else if (buf_level == '0)
                fill_reg <= 1'b1;
        end
    end

    // Compute stage counts the input period down to one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stage_valid_reg <= 1'b0;
            stage_cnt_reg   <= 8'h00;
            in_chan_reg     <= '0;
        end else if (load) begin
            stage_valid_reg <= 1'b1;
            stage_cnt_reg   <= period;
            in_chan_reg     <= next_chan;
        end else if (advance) begin
            stage_valid_reg <= 1'b0;
        end else if (clk_en && stage_valid_reg && stage_cnt_reg != 8'h01) begin
            stage_cnt_reg <= stage_cnt_reg - 8'h01;
        end
    end

    // Sample payload and history are data storage, never reset
    always_ff @(posedge mclk) begin
        if (load) begin
            stage_data_reg <= buf_beat.data;
            stage_chan_reg <= load_chan;
        end
        if (advance) begin
            hist_mem[stage_chan_reg] <= stage_data_reg;
        end
    end

    // Result slot holds until the consumer takes it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            out_beat_reg  <= '0;
            rcount_reg    <= '0;
        end else begin
            if (advance) begin
                out_valid_reg     <= 1'b1;
                out_beat_reg.data <= result;
                out_beat_reg.chan <= stage_chan_reg;
                out_beat_reg.sop  <= (stage_chan_reg == '0);
                out_beat_reg.eop  <= (stage_chan_reg == LAST_CH);
            end else if (source_ready) begin
                out_valid_reg <= 1'b0;
            end
            if (out_valid_reg && source_ready)
                rcount_reg <= rcount_reg + 32'h1;
        end
    end

    // Register write path: address and data may come in either order
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic        wstrb0_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    wire  wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire  wr_hit  = (awaddr_reg == FSC_OFS_CTRL)
                    || (awaddr_reg == FSC_OFS_CCOUNT)
                    || (awaddr_reg == FSC_OFS_UNITS);
    wire  wr_en   = wr_fire && wr_hit && wstrb0_reg;
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready  = !w_held_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0;
            wstrb0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= FSC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? FSC_RESP_OKAY : FSC_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Control fields all sit in byte lane zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            arch_reg   <= FSC_ARCH_PARALLEL;
            ccount_reg <= FSC_CCOUNT_RST;
            units_reg  <= FSC_UNITS_RST;
        end else if (wr_en) begin
            unique case (awaddr_reg)
                FSC_OFS_CTRL:
                    arch_reg <= fsc_arch_e'(wdata_reg[FSC_CTRL_ARCH_LSB +: 2]);
                FSC_OFS_CCOUNT: ccount_reg <= wdata_reg[7:0];
                FSC_OFS_UNITS:  units_reg  <= wdata_reg[3:0];
                default: ;
            endcase
        end
    end

    // Register read path, answer one cycle after the address is taken
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rd_mux;
    logic        rd_hit;
    wire  [7:0]  araddr_w = {s_axi_araddr[7:2], 2'b00};
    wire  [31:0] status_w;
    assign status_w = (32'(buf_level) << FSC_STAT_LVL_LSB)
                    | (32'(out_valid_reg) << FSC_STAT_OUT_BIT)
                    | (32'(stage_valid_reg) << FSC_STAT_BUSY_BIT)
                    | (32'(fill_reg) << FSC_STAT_FILL_BIT);
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_comb begin
        rd_hit = 1'b1;
        unique case (araddr_w)
            FSC_OFS_CTRL:   rd_mux = {30'h0, arch_reg};
            FSC_OFS_CCOUNT: rd_mux = {24'h0, ccount_reg};
            FSC_OFS_UNITS:  rd_mux = {28'h0, units_reg};
            FSC_OFS_STATUS: rd_mux = status_w;
            FSC_OFS_RCOUNT: rd_mux = rcount_reg;
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= FSC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_hit ? FSC_RESP_OKAY : FSC_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Checks on the stream behaviour
    a_reset_outs_low: assert property (@(posedge mclk)
        !rst_n |-> !sink_ready && !source_valid)
        else $error("accept or present high during reset");
    a_release_accept: assert property (@(posedge mclk)
        $rose(rst_n) |=> sink_ready)
        else $error("accept not raised after reset release");
    a_stall_freeze: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !clk_en && stage_valid_reg |=> stage_valid_reg
            && stage_cnt_reg == $past(stage_cnt_reg))
        else $error("compute moved while enable low");
    a_present_drop: assert property (@(posedge mclk)
        disable iff (!rst_n)
        source_valid && source_ready && !advance |=> !source_valid)
        else $error("present stayed high with no result");
    a_full_rate: assert property (@(posedge mclk)
        disable iff (!rst_n)
        arch_reg == FSC_ARCH_PARALLEL && clk_en && stage_valid_reg
            && source_ready |-> advance)
        else $error("parallel mode missed a cycle");
    a_take_counts: assert property (@(posedge mclk)
        disable iff (!rst_n)
        take && !load |=> buf_level == $past(buf_level) + 1'b1)
        else $error("accepted sample not buffered");
    a_group_marks: assert property (@(posedge mclk)
        disable iff (!rst_n)
        source_valid |-> source_beat.sop == (source_beat.chan == '0)
            && source_beat.eop == (source_beat.chan == LAST_CH))
        else $error("group markers disagree with channel");
    a_chan_follows: assert property (@(posedge mclk)
        disable iff (!rst_n)
        advance |=> source_beat.chan == $past(stage_chan_reg))
        else $error("result channel wrong");
    a_period_spacing: assert property (@(posedge mclk)
        disable iff (!rst_n)
        load && clk_en |=> stage_cnt_reg == $past(period))
        else $error("period not loaded");
    a_idle_halts: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !stage_valid_reg && !buf_out_valid |=> !stage_valid_reg)
        else $error("compute ran with empty buffer");
    a_hold_stall: assert property (@(posedge mclk)
        disable iff (!rst_n)
        source_valid && !source_ready |=> source_valid
            && $stable(source_beat))
        else $error("result changed while stalled");
endmodule : fsc_stream_ctrl
`default_nettype wire

// [pkg/fsc_pkg.sv]
// Constants, types and register map for the filter stream control block
package fsc_pkg;

    // Stream widths and channel count
    localparam int unsigned FSC_DATA_W = 16;
    localparam int unsigned FSC_OUT_W  = 17;
    localparam int unsigned FSC_NUM_CH = 3;
    localparam int unsigned FSC_CH_W   =
        (FSC_NUM_CH > 1) ? $clog2(FSC_NUM_CH) : 1;

    // Register byte offsets on the register bus
    localparam logic [7:0] FSC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] FSC_OFS_CCOUNT = 8'h04;
    localparam logic [7:0] FSC_OFS_UNITS  = 8'h08;
    localparam logic [7:0] FSC_OFS_STATUS = 8'h0c;
    localparam logic [7:0] FSC_OFS_RCOUNT = 8'h10;

    // Field positions and reset values
    localparam int unsigned FSC_CTRL_ARCH_LSB = 0;
    localparam int unsigned FSC_STAT_LVL_LSB  = 0;
    localparam int unsigned FSC_STAT_OUT_BIT  = 8;
    localparam int unsigned FSC_STAT_BUSY_BIT = 9;
    localparam int unsigned FSC_STAT_FILL_BIT = 10;
    localparam logic [7:0]  FSC_CCOUNT_RST    = 8'h01;
    localparam logic [3:0]  FSC_UNITS_RST     = 4'h1;

    // Bus response codes
    localparam logic [1:0] FSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] FSC_RESP_SLVERR = 2'h2;

    // Filter architectures
    typedef enum logic [1:0] {
        FSC_ARCH_PARALLEL                        = 2'b00,
        FSC_ARCH_MULTICYCLE_VARIABLE_ARCHITECTURE = 2'b01,
        FSC_ARCH_MULTIBIT_SERIAL                 = 2'b10,
        FSC_ARCH_SERIAL                          = 2'b11
    } fsc_arch_e;

    // Input beat from the upstream provider
    typedef struct packed {
        logic                  sop;
        logic                  eop;
        logic [FSC_DATA_W-1:0] data;
    } fsc_sink_s;

    // Result beat to the downstream consumer
    typedef struct packed {
        logic                  sop;
        logic                  eop;
        logic [FSC_CH_W-1:0]   chan;
        logic [FSC_OUT_W-1:0]  data;
    } fsc_source_s;

endpackage : fsc_pkg

// [tb/fsc_partner.sv]
// Upstream sample producer and downstream result consumer models
`timescale 1ns/1ps
`default_nettype none
module fsc_partner
    import fsc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       send,
    input  wire logic       zeros,
    input  wire logic       stall,
    input  wire logic       sink_ready,
    output var logic        sink_valid,
    output var fsc_sink_s   sink_beat,
    input  wire logic       source_valid,
    output var logic        source_ready
);
    int   ch;
    logic tk;

    // Quiet lines until the first edge
    initial begin
        sink_valid = 1'b0;
        sink_beat = '0;
        source_ready = 1'b1;
    end

    // Offer holds until taken; markers follow the channel order
    always @(posedge mclk) begin
        tk = sink_valid && sink_ready;
        if (tk)
            ch = (ch == FSC_NUM_CH - 1) ? 0 : ch + 1;
        if (!rst_n) begin
            ch = 0;
            sink_valid <= 1'b0;
        end else if (send && (tk || !sink_valid)) begin
            sink_valid <= 1'b1;
            sink_beat.sop <= (ch == 0);
            sink_beat.eop <= (ch == FSC_NUM_CH - 1);
            sink_beat.data <= zeros ? '0 : FSC_DATA_W'($urandom);
        end else if (tk) begin
            // Released lines flip so a stale copy never looks valid
            sink_valid <= 1'b0;
            sink_beat <= ~sink_beat;
        end
    end

    // Random back-pressure only when the bench asks for it
    always @(posedge mclk)
        source_ready <= stall ? 1'($urandom) : 1'b1;

endmodule : fsc_partner
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the filter stream control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fsc_pkg::*;
    logic mclk, rst_n, clk_en, send, zeros, stall;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, sink_valid, sink_ready;
    logic source_valid, source_ready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    fsc_sink_s   sink_beat;
    fsc_source_s source_beat, e;
    fsc_source_s q[$];
    bit          qk[$];
    int mismatches, num_checks, cyc, mch, rcnt, last_t, min_gap, takes, pc;
    int hist[FSC_NUM_CH];
    bit known[FSC_NUM_CH];
    bit saw_low;
    int ta[5] = '{0, 1, 1, 2, 3};
    int tc[5] = '{3, 1, 3, 3, 3};
    int tn[5] = '{1, 1, 3, 4, 17};

    fsc_stream_ctrl dut (.mclk, .rst_n, .clk_en, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .sink_valid, .sink_ready, .sink_beat, .source_valid,
        .source_ready, .source_beat);
    fsc_partner pm (.mclk, .rst_n, .send, .zeros, .stall, .sink_ready,
        .sink_valid, .sink_beat, .source_valid, .source_ready);

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // A hung handshake ends the run as a failure
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // Reference model: per-channel history kept across reset
    always @(posedge mclk) begin
        if (!rst_n) begin
            q.delete();
            qk.delete();
            mch = 0;
            rcnt = 0;
        end else begin
            if (sink_valid && !sink_ready)
                saw_low = 1;
            if (sink_valid && sink_ready) begin
                takes++;
                e.sop = (mch == 0);
                e.eop = (mch == FSC_NUM_CH - 1);
                e.chan = FSC_CH_W'(mch);
                e.data = FSC_OUT_W'($signed(sink_beat.data) + hist[mch]);
                q.push_back(e);
                qk.push_back(known[mch]);
                hist[mch] = $signed(sink_beat.data);
                known[mch] = 1;
                mch = (mch + 1) % FSC_NUM_CH;
            end
            if (source_valid && source_ready) begin
                rcnt++;
                if (cyc - last_t < min_gap)
                    min_gap = cyc - last_t;
                last_t = cyc;
                if (q.size() == 0)
                    check(64'(1), 64'(0));
                else begin
                    e = q.pop_front();
                    // History not yet flushed is unknown, so markers only
                    if (qk.pop_front())
                        check(64'(source_beat), 64'(e));
                    else
                        check(64'({source_beat.sop, source_beat.eop,
                            source_beat.chan}), 64'({e.sop, e.eop, e.chan}));
                end
            end
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        bit aw = 1;
        bit w = 1;
        @(posedge mclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge mclk);
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge mclk);
        s_axi_bready <= 1'b0;
        check(64'(s_axi_bresp), 64'(er));
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge mclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge mclk);
        s_axi_rready <= 1'b0;
        check(64'({s_axi_rresp, s_axi_rdata}), 64'({er, ed}));
    endtask : axi_rd

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        check(64'({sink_ready, source_valid}), 64'(0));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 check(64'(sink_ready), 64'(1));
    endtask : do_reset

    task automatic drain();
        int n = 0;
        send <= 1'b0;
        while (n < 2000 && (q.size() != 0 || sink_valid)) begin
            @(posedge mclk);
            n++;
        end
        repeat (4) @(posedge mclk);
        check(64'({q.size(), sink_valid, source_valid}), 64'(0));
    endtask : drain

    // Main sequence
    initial begin
        {rst_n, send, zeros, stall, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        clk_en = 1'b1;
        void'($urandom(74395));
        do_reset();
        axi_rd(FSC_OFS_CTRL, 32'h0, FSC_RESP_OKAY);
        axi_rd(FSC_OFS_CCOUNT, 32'(FSC_CCOUNT_RST), FSC_RESP_OKAY);
        axi_rd(FSC_OFS_UNITS, 32'(FSC_UNITS_RST), FSC_RESP_OKAY);
        axi_rd(8'h20, 32'h0, FSC_RESP_SLVERR);
        axi_wr(FSC_OFS_STATUS, 32'h5, FSC_RESP_SLVERR);
        // Zeros first so every channel's history becomes known
        zeros <= 1'b1;
        send <= 1'b1;
        stall <= 1'b1;
        while (takes < 6) @(posedge mclk);
        zeros <= 1'b0;
        repeat (200) @(posedge mclk);
        drain();
        // Input period per architecture with the provider never pausing
        stall <= 1'b0;
        axi_wr(FSC_OFS_UNITS, 32'h4, FSC_RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            axi_wr(FSC_OFS_CTRL, 32'(ta[i]), FSC_RESP_OKAY);
            axi_wr(FSC_OFS_CCOUNT, 32'(tc[i]), FSC_RESP_OKAY);
            min_gap = 1000;
            saw_low = 0;
            send <= 1'b1;
            repeat (10 * tn[i] + 40) @(posedge mclk);
            drain();
            check(64'(min_gap), 64'(tn[i]));
            if (tn[i] > 1)
                check(64'(saw_low), 64'(1));
        end
        // Provider paces itself once per random compute period
        pc = 2 + $urandom % 4;
        axi_wr(FSC_OFS_CTRL, 32'h1, FSC_RESP_OKAY);
        axi_wr(FSC_OFS_CCOUNT, 32'(pc), FSC_RESP_OKAY);
        min_gap = 1000;
        repeat (30) begin
            send <= 1'b1;
            @(posedge mclk);
            send <= 1'b0;
            repeat (pc - 1) @(posedge mclk);
        end
        drain();
        check(64'(min_gap), 64'(pc));
        // Byte lane zero off: write answers OKAY but changes nothing
        s_axi_wstrb <= 4'he;
        axi_wr(FSC_OFS_CTRL, 32'h3, FSC_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_rd(FSC_OFS_CTRL, 32'h1, FSC_RESP_OKAY);
        // Enable low: buffer fills, accept drops, results run dry
        axi_wr(FSC_OFS_CTRL, 32'h0, FSC_RESP_OKAY);
        send <= 1'b1;
        repeat (20) @(posedge mclk);
        clk_en <= 1'b0;
        repeat (30) @(posedge mclk);
        check(64'({sink_ready, source_valid}), 64'(0));
        // Default depth of six held, stage frozen busy, refill off
        pc = (6 << FSC_STAT_LVL_LSB) | (1 << FSC_STAT_BUSY_BIT);
        axi_rd(FSC_OFS_STATUS, 32'(pc), FSC_RESP_OKAY);
        clk_en <= 1'b1;
        repeat (30) @(posedge mclk);
        drain();
        // Second reset keeps history that the model still expects
        stall <= 1'b1;
        send <= 1'b1;
        repeat (40) @(posedge mclk);
        drain();
        do_reset();
        send <= 1'b1;
        repeat (60) @(posedge mclk);
        drain();
        axi_rd(FSC_OFS_RCOUNT, 32'(rcnt), FSC_RESP_OKAY);
        final_report();
    end

endmodule : tb
`default_nettype wire
